// [core/intc_cfg_params.svh]
/*
 Register map, field positions and reset values of the interrupt
 global configuration block.
 Assumes: included by bare name from the package and the core files.
*/
`ifndef INTC_CFG_PARAMS_SVH
`define INTC_CFG_PARAMS_SVH

// Byte addresses on the register bus, bits [7:0] of the address
`define ICC_ADR_CTRL         8'h00
`define ICC_ADR_STATUS       8'h04
`define ICC_ADR_MASK         8'h08

// Field positions of the global control register
`define ICC_BIT_SHADOW       16
`define ICC_BIT_VMODE        12
`define ICC_TPC_MSB          10
`define ICC_TPC_LSB          8
`define ICC_EDGE_MSB         4
`define ICC_EDGE_LSB         0

// Implemented bits of the control register
`define ICC_CTRL_WMASK       32'h0001_171F
`define ICC_CTRL_RESET       32'h0000_0000

// Status and mask layout: [4:0] external edges, [5] proximity start
`define ICC_EVT_W            6
`define ICC_EVT_PROX         5
`define ICC_STATUS_RESET     6'h00
`define ICC_MASK_RESET       6'h00

// Proximity threshold codes
`define ICC_TPC_OFF          3'h0
`define ICC_TPC_ONLY1        3'h1

`endif

// [core/intc_cfg_pkg.sv]
/*
 Types shared by the interrupt global configuration block.
 Assumes: intc_cfg_params.svh is on the include path.
*/
`include "intc_cfg_params.svh"

package intc_cfg_pkg;

   // Writable fields of the global control register
   typedef struct packed {
      logic       single_vector_shadow_select;
      logic       vector_mode_select;
      logic [2:0] proximity_threshold;
      logic [4:0] ext_irq_edge_select;
   } ctrl_type;

   // Wishbone answer state, one bit so naturally Gray
   typedef enum logic [0:0] {
      WB_IDLE = 1'b0,
      WB_ACK  = 1'b1
   } wb_state_type;

endpackage : intc_cfg_pkg

// [core/ext_edge_detect.sv]
/*
 Synchronises the five external interrupt pins and reports the
 selected edge of each as a one-cycle pulse.
 Assumes: pins are asynchronous to i_core_clk; edge selects come
 from registers on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ext_edge_detect (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic [4:0] i_pin,
   input  wire logic [4:0] i_rising_sel,
   output var  logic [4:0] o_event
);

   logic [4:0] meta_ff;
   logic [4:0] sync_ff;
   logic [4:0] prev_ff;
   logic [4:0] nxt_event;

   // Edge choice per pin; a select change alone makes no edge
   assign nxt_event = (i_rising_sel & sync_ff & ~prev_ff)
                    | (~i_rising_sel & ~sync_ff & prev_ff);

   // Two-stage synchroniser, then history and pulse
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= 5'h00;
         sync_ff <= 5'h00;
         prev_ff <= 5'h00;
         o_event <= 5'h00;
      end else begin
         meta_ff <= i_pin;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         o_event <= nxt_event;
      end
   end

endmodule : ext_edge_detect

`default_nettype wire

// [core/interrupt_control_config.sv]
/*
 Global configuration of the interrupt controller: vector mode,
 shadow set choice, proximity threshold and external edge polarity,
 reached over a classic Wishbone slave, with sticky event status.
 Assumes: one 20 MHz clock; pending-request inputs come from logic on
 the same clock; external pins are asynchronous.

*/
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "intc_cfg_params.svh"

module interrupt_control_config (
   input  wire logic                      i_core_clk,
   input  wire logic                      i_rst_n,
   // Wishbone classic slave
   input  wire logic                      i_wb_cyc,
   input  wire logic                      i_wb_stb,
   input  wire logic                      i_wb_we,
   input  wire logic [7:0]                i_wb_adr,
   input  wire logic [3:0]                i_wb_sel,
   input  wire logic [31:0]               i_wb_dat,
   output var  logic [31:0]               o_wb_dat,
   output var  logic                      o_wb_ack,
   // External interrupt pins
   input  wire logic [4:0]                i_ext_irq,
   // Pending request seen by the priority logic
   input  wire logic                      i_pend_valid,
   input  wire logic [2:0]                i_pend_group_priority,
   // Towards the processor core
   output var  intc_cfg_pkg::ctrl_type    o_cfg,
   output var  logic                      o_prox_start,
   output var  logic [4:0]                o_ext_irq_event,
   output var  logic                      o_irq
);

   ////////////////////////////////////////////////////////////////////
   // Declarations

   intc_cfg_pkg::wb_state_type state_ff;
   intc_cfg_pkg::wb_state_type nxt_state;
   intc_cfg_pkg::ctrl_type     nxt_cfg;

   // Reset word kept whole so every field's reset comes from one constant
   localparam logic [31:0] ctrl_rst_word = `ICC_CTRL_RESET;

   logic [`ICC_EVT_W-1:0] status_ff;
   logic [`ICC_EVT_W-1:0] nxt_status;
   logic [`ICC_EVT_W-1:0] mask_ff;
   logic [`ICC_EVT_W-1:0] nxt_mask;
   logic [`ICC_EVT_W-1:0] events;
   logic [4:0]            edge_event;
   logic [31:0]           nxt_rd_data;
   logic [31:0]           ctrl_word;
   logic [31:0]           ctrl_merged;
   logic [31:0]           mask_merged;
   logic [31:0]           w1c_bits;
   logic                  req;
   logic                  wr_commit;
   logic                  wr_ctrl;
   logic                  wr_status;
   logic                  wr_mask;
   logic                  hit_ctrl;
   logic                  hit_status;
   logic                  hit_mask;
   logic                  prox_hit;
   logic                  nxt_prox_start;
   logic                  nxt_irq;

   ////////////////////////////////////////////////////////////////////
   // Functions

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   // Control fields placed at their word positions
   function automatic logic [31:0] ctrl_to_word(input intc_cfg_pkg::ctrl_type c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`ICC_BIT_SHADOW]              = c.single_vector_shadow_select;
      w[`ICC_BIT_VMODE]               = c.vector_mode_select;
      w[`ICC_TPC_MSB:`ICC_TPC_LSB]    = c.proximity_threshold;
      w[`ICC_EDGE_MSB:`ICC_EDGE_LSB]  = c.ext_irq_edge_select;
      return w;
   endfunction : ctrl_to_word

   ////////////////////////////////////////////////////////////////////
   // Bus decode

   // Request, decode and commit strobe
   assign req        = i_wb_cyc & i_wb_stb;
   assign hit_ctrl   = (i_wb_adr == `ICC_ADR_CTRL);
   assign hit_status = (i_wb_adr == `ICC_ADR_STATUS);
   assign hit_mask   = (i_wb_adr == `ICC_ADR_MASK);
   // Writes land on the edge where ack is seen, matching the master
   assign wr_commit  = req & i_wb_we & (state_ff == intc_cfg_pkg::WB_ACK);
   assign wr_ctrl    = wr_commit & hit_ctrl;
   assign wr_status  = wr_commit & hit_status;
   assign wr_mask    = wr_commit & hit_mask;

   // Answer one cycle after the request, drop the cycle after
   assign nxt_state = (req && state_ff == intc_cfg_pkg::WB_IDLE) ?
                      intc_cfg_pkg::WB_ACK : intc_cfg_pkg::WB_IDLE;

   ////////////////////////////////////////////////////////////////////
   // Control register

   // Only implemented bits survive a write
   assign ctrl_word   = ctrl_to_word(o_cfg);
   assign ctrl_merged = lane_merge(ctrl_word, i_wb_dat, i_wb_sel)
                      & `ICC_CTRL_WMASK;
   assign nxt_cfg.single_vector_shadow_select =
      wr_ctrl ? ctrl_merged[`ICC_BIT_SHADOW] : o_cfg.single_vector_shadow_select;
   assign nxt_cfg.vector_mode_select =
      wr_ctrl ? ctrl_merged[`ICC_BIT_VMODE] : o_cfg.vector_mode_select;
   assign nxt_cfg.proximity_threshold =
      wr_ctrl ? ctrl_merged[`ICC_TPC_MSB:`ICC_TPC_LSB] : o_cfg.proximity_threshold;
   assign nxt_cfg.ext_irq_edge_select =
      wr_ctrl ? ctrl_merged[`ICC_EDGE_MSB:`ICC_EDGE_LSB]
              : o_cfg.ext_irq_edge_select;

   // Reset leaves single-vector, no shadow, timer off, falling edges
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cfg <= {ctrl_rst_word[`ICC_BIT_SHADOW], ctrl_rst_word[`ICC_BIT_VMODE],
                   ctrl_rst_word[`ICC_TPC_MSB:`ICC_TPC_LSB],
                   ctrl_rst_word[`ICC_EDGE_MSB:`ICC_EDGE_LSB]};
      end else begin
         o_cfg <= nxt_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Proximity threshold compare

   // Priority 0 never qualifies; code 0 disables, code 1 admits only 1
   assign prox_hit = (o_cfg.proximity_threshold != `ICC_TPC_OFF)
                   && (i_pend_group_priority != 3'h0)
                   && (i_pend_group_priority <= o_cfg.proximity_threshold);
   assign nxt_prox_start = i_pend_valid & prox_hit;

   ////////////////////////////////////////////////////////////////////
   // External edge detection

   // Polarity per pin comes straight from the control register
   ext_edge_detect u_edge (
      .i_core_clk   (i_core_clk),
      .i_rst_n      (i_rst_n),
      .i_pin        (i_ext_irq),
      .i_rising_sel (o_cfg.ext_irq_edge_select),
      .o_event      (edge_event)
   );

   ////////////////////////////////////////////////////////////////////
   // Event status and mask

   // Event set wins over a same-cycle write-one clear
   assign events      = {o_prox_start, edge_event};
   assign w1c_bits    = wr_status ? lane_merge(32'h0000_0000, i_wb_dat, i_wb_sel)
                                  : 32'h0000_0000;
   assign nxt_status  = (status_ff & ~w1c_bits[`ICC_EVT_W-1:0]) | events;
   assign mask_merged = lane_merge({26'h000_0000, mask_ff}, i_wb_dat, i_wb_sel);
   assign nxt_mask    = wr_mask ? mask_merged[`ICC_EVT_W-1:0] : mask_ff;
   // Registered level, one cycle behind the status it reflects
   assign nxt_irq     = |(status_ff & mask_ff);

   // Read mux, zero for unmapped addresses and unimplemented bits
   assign nxt_rd_data = hit_ctrl   ? ctrl_word :
                        hit_status ? {26'h000_0000, status_ff} :
                        hit_mask   ? {26'h000_0000, mask_ff} :
                                     32'h0000_0000;

   ////////////////////////////////////////////////////////////////////
   // Bus answer, status and output registers

   // Wishbone handshake and read capture
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= intc_cfg_pkg::WB_IDLE;
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         o_wb_ack <= (nxt_state == intc_cfg_pkg::WB_ACK);
         o_wb_dat <= (nxt_state == intc_cfg_pkg::WB_ACK) ? nxt_rd_data
                                                         : 32'h0000_0000;
      end
   end

   // Sticky status, mask and event outputs
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_ff       <= `ICC_STATUS_RESET;
         mask_ff         <= `ICC_MASK_RESET;
         o_prox_start    <= 1'b0;
         o_ext_irq_event <= 5'h00;
         o_irq           <= 1'b0;
      end else begin
         status_ff       <= nxt_status;
         mask_ff         <= nxt_mask;
         o_prox_start    <= nxt_prox_start;
         o_ext_irq_event <= edge_event;
         o_irq           <= nxt_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions

   // Shadow select follows bit 16 of a committed write
   property p_shadow_write;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_ctrl && i_wb_sel[2]) |=>
         (o_cfg.single_vector_shadow_select == $past(i_wb_dat[16]));
   endproperty
   a_shadow_write: assert property (p_shadow_write)
      else $error("shadow select did not take bit 16");

   // Vector mode follows bit 12 and holds without a write
   property p_vmode_write;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_ctrl && i_wb_sel[1]) |=>
         (o_cfg.vector_mode_select == $past(i_wb_dat[12]))
         ##1 ($past(wr_ctrl) || $stable(o_cfg.vector_mode_select));
   endproperty
   a_vmode_write: assert property (p_vmode_write)
      else $error("vector mode did not follow bit 12");

   // Qualifying priority at threshold 2..7 starts the timer next cycle
   property p_prox_window;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_pend_valid && o_cfg.proximity_threshold >= 3'h2
       && i_pend_group_priority != 3'h0
       && i_pend_group_priority <= o_cfg.proximity_threshold)
      |=> o_prox_start ##1 status_ff[`ICC_EVT_PROX];
   endproperty
   a_prox_window: assert property (p_prox_window)
      else $error("qualifying priority missed proximity start");

   // Priority above threshold never starts the timer
   property p_prox_above;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_pend_group_priority > o_cfg.proximity_threshold) |=> !o_prox_start;
   endproperty
   a_prox_above: assert property (p_prox_above)
      else $error("priority above threshold started timer");

   // Threshold one admits priority 1 only
   property p_prox_only1;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_cfg.proximity_threshold == `ICC_TPC_ONLY1 && i_pend_valid)
      |=> (o_prox_start == ($past(i_pend_group_priority) == 3'h1));
   endproperty
   a_prox_only1: assert property (p_prox_only1)
      else $error("threshold one misjudged priority");

   // Threshold zero: no start at all
   property p_prox_off;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_cfg.proximity_threshold == `ICC_TPC_OFF) |=> !o_prox_start;
   endproperty
   a_prox_off: assert property (p_prox_off)
      else $error("disabled timer was started");

   // Edge selects follow the low byte of a committed write
   property p_edge_write;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_ctrl && i_wb_sel[0]) |=>
         (o_cfg.ext_irq_edge_select == $past(i_wb_dat[4:0]));
   endproperty
   a_edge_write: assert property (p_edge_write)
      else $error("edge select did not follow write");

   // Reserved control bits read back as zero
   property p_reserved_zero;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (req && !i_wb_we && hit_ctrl && state_ff == intc_cfg_pkg::WB_IDLE)
      |=> o_wb_ack && ((o_wb_dat & ~`ICC_CTRL_WMASK) == 32'h0000_0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved control bit read nonzero");

   // Control fields cleared right after reset release
   property p_reset_clear;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> (ctrl_word == `ICC_CTRL_RESET)
                         && (status_ff == `ICC_STATUS_RESET);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("control not cleared by reset");

   // Ack is a single-cycle pulse and follows a request
   property p_ack_pulse;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_wb_ack |-> $past(req) ##1 !o_wb_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack not a one-cycle answer");

   // Interrupt line tracks masked status one cycle later
   property p_irq_level;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      ##1 (o_irq == |($past(status_ff) & $past(mask_ff)));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt line disagrees with status");

   // Every event lands in status; a lost set would hide an interrupt
   property p_status_sticky;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (|events) |=> ((status_ff & $past(events)) == $past(events));
   endproperty
   a_status_sticky: assert property (p_status_sticky)
      else $error("event did not set its status bit");

   // Writing one clears the proximity status bit when no new event
   property p_w1c_clear;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_status && i_wb_sel[0] && i_wb_dat[`ICC_EVT_PROX]
       && !events[`ICC_EVT_PROX]) |=> !status_ff[`ICC_EVT_PROX];
   endproperty
   a_w1c_clear: assert property (p_w1c_clear)
      else $error("write-one did not clear status");

   // Mask follows the low byte of a committed write
   property p_mask_write;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (wr_mask && i_wb_sel[0]) |=>
         (mask_ff == $past(i_wb_dat[`ICC_EVT_W-1:0]));
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask did not follow write");

endmodule : interrupt_control_config

`default_nettype wire

// [verification/core_model.sv]
/*
 Model of the processor core side: raises one pending request of a
 given group priority on command, and counts proximity-timer starts.
 Assumes: same clock and reset as the configuration block.
*/
`timescale 1ns/10ps
`default_nettype none

module core_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_go,
   input  wire logic [2:0] i_prio,
   input  wire logic       i_prox_start,
   output var  logic       o_pend_valid,
   output var  logic [2:0] o_pend_prio,
   output var  int         o_hits
);
   ////////////////////////////////////////////////////////////////////
   // One-cycle request; priority toggles when idle so stale values
   // cannot pass for a real request
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pend_valid <= 1'b0;
         o_pend_prio  <= 3'h0;
         o_hits       <= 0;
      end else begin
         o_pend_valid <= i_go;
         o_pend_prio  <= i_go ? i_prio : ~o_pend_prio;
         if (i_prox_start) begin
            o_hits <= o_hits + 1;
         end
      end
   end
endmodule : core_model
`default_nettype wire

// [verification/tb.sv]
/*
 Self-checking bench of the interrupt global configuration block.
 Assumes: classic Wishbone with a one-cycle answer; core_model drives
 the pending request.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
   logic                   i_core_clk = 1'b0;
   logic                   i_rst_n    = 1'b0;
   logic                   cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
   logic [7:0]             adr = 8'h00;
   logic [3:0]             sel = 4'h0;
   logic [31:0]            wdat = 32'h0000_0000, rdat, q;
   logic [4:0]             ext = 5'h00, evt, acc;
   logic [2:0]             prio = 3'h0, pprio;
   logic                   pvalid, ack, prox, irq;
   intc_cfg_pkg::ctrl_type cfg;
   int                     hits, h, err_count = 0, comparisons = 0;
   logic [63:0]            rows [6] = '{64'hFFFF_FFFF_0001_171F,
      64'h0001_0000_0001_0000, 64'h0000_1000_0000_1000,
      64'hFFFE_E8E0_0000_0000, 64'h0000_0700_0000_0700,
      64'h0000_0015_0000_0015};

   always #25 i_core_clk = ~i_core_clk;

   interrupt_control_config dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_ext_irq(ext), .i_pend_valid(pvalid), .i_pend_group_priority(pprio),
      .o_cfg(cfg), .o_prox_start(prox), .o_ext_irq_event(evt), .o_irq(irq));

   core_model u_core (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_go(go),
      .i_prio(prio), .i_prox_start(prox), .o_pend_valid(pvalid),
      .o_pend_prio(pprio), .o_hits(hits));

   ////////////////////////////////////////////////////////////////////
   // Compare and verdict helpers
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic summarize;
      $display("checks %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize

   // Classic single cycle; entered just after a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      if (n >= 20) chk(32'h0000_0001, 32'h0000_0000);
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge i_core_clk);
   endtask : wb

   // One pending request through the core model, then count starts
   task automatic pend(input logic [2:0] p, input logic exp);
      h = hits;
      go <= 1'b1; prio <= p;
      @(posedge i_core_clk);
      go <= 1'b0;
      repeat (5) @(posedge i_core_clk);
      chk(32'(hits - h), {31'h0, exp});
   endtask : pend

   ////////////////////////////////////////////////////////////////////
   // Hang guard, generous against roughly 530 cycles of tests
   initial begin
      repeat (20000) @(posedge i_core_clk);
      err_count++;
      summarize();
   end

   // Main sequence
   initial begin
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      chk({22'h0, cfg}, 32'h0000_0000);
      wb(1'b0, 8'h00, 32'h0, q); chk(q, 32'h0000_0000);
      $display("reset test done");
      // Table rows: write data beside expected readback
      foreach (rows[i]) begin
         wb(1'b1, 8'h00, rows[i][63:32], q);
         wb(1'b0, 8'h00, 32'h0, q);
         chk(q, rows[i][31:0]);
         chk({22'h0, cfg}, {22'h0, rows[i][16], rows[i][12], rows[i][10:8], rows[i][4:0]});
      end
      $display("row test done");
      // Every threshold against every priority
      for (int t = 0; t < 8; t++) begin
         wb(1'b1, 8'h00, {21'h0, 3'(t), 8'h00}, q);
         for (int p = 0; p < 8; p++) begin
            pend(3'(p), t != 0 && p >= 1 && p <= t);
         end
      end
      $display("threshold test done");
      // Mixed edge polarity: rising on 0,2,4, falling on 1,3
      wb(1'b1, 8'h00, 32'h0000_0015, q);
      wb(1'b1, 8'h04, 32'h0000_003F, q);
      ext <= 5'h1F;
      acc = 5'h00;
      repeat (8) begin
         @(posedge i_core_clk);
         acc = acc | evt;
      end
      chk({27'h0, acc}, 32'h0000_0015);
      wb(1'b0, 8'h04, 32'h0, q); chk(q, 32'h0000_0015);
      wb(1'b1, 8'h04, 32'h0000_003F, q);
      ext <= 5'h00;
      acc = 5'h00;
      repeat (8) begin
         @(posedge i_core_clk);
         acc = acc | evt;
      end
      chk({27'h0, acc}, 32'h0000_000A);
      wb(1'b0, 8'h04, 32'h0, q); chk(q, 32'h0000_000A);
      wb(1'b1, 8'h04, 32'h0000_003F, q);
      $display("edge test done");
      // Interrupt: raise, mask, unmask, clear
      wb(1'b1, 8'h08, 32'h0000_0020, q);
      wb(1'b1, 8'h00, 32'h0000_0700, q);
      chk({31'h0, irq}, 32'h0);
      pend(3'h3, 1'b1);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, 8'h08, 32'h0, q);
      repeat (2) @(posedge i_core_clk);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, 8'h08, 32'h0000_0020, q);
      repeat (2) @(posedge i_core_clk);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, 8'h04, 32'h0000_0020, q);
      repeat (2) @(posedge i_core_clk);
      chk({31'h0, irq}, 32'h0);
      wb(1'b0, 8'h04, 32'h0, q); chk(q, 32'h0000_0000);
      $display("interrupt test done");
      // Unmapped address answers and reads zero
      wb(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
      wb(1'b0, 8'h0C, 32'h0, q); chk(q, 32'h0000_0000);
      // Second reset in mid-run clears the control fields
      wb(1'b1, 8'h00, 32'hFFFF_FFFF, q);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      chk({22'h0, cfg}, 32'h0000_0000);
      wb(1'b0, 8'h00, 32'h0, q); chk(q, 32'h0000_0000);
      $display("second reset test done");
      summarize();
   end
endmodule : tb
`default_nettype wire
